//--- rtl/opc_defines.svh
// Constants of the operator panel controller: map, fields, resets and timing.
`ifndef OPC_DEFINES_SVH
`define OPC_DEFINES_SVH
`define OPC_CLK_NS          40
`define OPC_SCAN_DWELL_NS   100000
`define OPC_SCAN_DWELL_CYC  ((`OPC_SCAN_DWELL_NS + `OPC_CLK_NS - 1) / `OPC_CLK_NS)
`define OPC_PROG_LSB        14
`define OPC_RAM_LSB         13
`define OPC_PROG0_TAG       2'h0
`define OPC_PROG1_TAG       2'h1
`define OPC_RAM_TAG         3'h4
`define OPC_IO_PIO          4'h0
`define OPC_IO_CTC          4'h1
`define OPC_IO_UART         4'h2
`define OPC_IO_DISP         4'h3
`define OPC_IO_SENT         3'h2
`define OPC_CS_PROG0        0
`define OPC_CS_PROG1        1
`define OPC_CS_RAM          2
`define OPC_CS_PIO          3
`define OPC_CS_CTC          4
`define OPC_CS_UART         5
`define OPC_CS_DISP         6
`define OPC_CS_SENT         7
`define OPC_PIO_A           2'h0
`define OPC_PIO_B           2'h1
`define OPC_PIO_SEL         2'h2
`define OPC_BUZ_BIT         7
`define OPC_REMOTE_BIT      6
`define OPC_ARM_BIT         5
`define OPC_CTC_RELOAD      2'h0
`define OPC_CTC_COUNT       2'h1
`define OPC_CTC_STAT        2'h2
`define OPC_CTC_RELOAD_RST  8'hff
`define OPC_UART_DATA       2'h0
`define OPC_UART_STAT       2'h1
`define OPC_UART_OSC_DIV    5'h17
`define OPC_UART_OVS_MID    4'h7
`define OPC_TX_BITS         4'ha
`define OPC_RX_BITS         4'h9
`define OPC_SYNC_BYTE       8'h16
`define OPC_ACK_BYTE        8'h06
`define OPC_NAK_BYTE        8'h15
`define OPC_FIFO_DEPTH      32
`endif

//--- rtl/opc_pkg.sv
// Types shared by the operator panel controller.
package opc_pkg;
  typedef enum logic [1:0] {LNK_HUNT, LNK_UP} opc_link_t;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} opc_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} opc_rx_t;
endpackage

//--- rtl/opc_top.sv
// Operator panel controller: bus decoder, key scan, timer, serial link, display strobes.
`timescale 1ns/100ps
`include "opc_defines.svh"

module opc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce_i) begin
      // Pointers wrap naturally because the depth is a power of two
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Overview of operation
// - Keys form four columns by eight rows
// - Sentinel: eight units, 32 characters, processor written
// - Three numeric groups, each its own driver
// - Groups: volume/rate/rise, limit/duration, program/levels/delay
// - Lamp driver rows, three enabled lamp columns
// - Exchange messages until error-free link after start
// - 8-bit data, 16-bit address, 5-line control
// - Processor clock is reference divided by two
// - Serial bit timing from own oscillator
// - Two 16K program memories, one 8K RAM
// - Decoder asserts at most one chip select
// - Twelve port lines scan the key matrix
// - Port A bit 7 drives buzzer
// - Port A bit 6 reads remote switch
// - Port A bit 5 lights arm lamp
// - Port A outputs 5 and 7 are inverted
// - Counter-timer times events, raises processor interrupt
// - Serial receive fills holding register, requests interrupt
// - Display decoder strobes four display drivers
// - All bus cycles complete without wait states
module opc_top (
  // Clock, reset, enable
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       ce_i,
  // Processor bus
  input  wire logic [15:0] bus_addr_i,
  input  wire logic [7:0]  bus_data_i,
  input  wire logic        bus_mreq_n_i,
  input  wire logic        bus_iorq_n_i,
  input  wire logic        bus_rd_n_i,
  input  wire logic        bus_wr_n_i,
  input  wire logic        bus_inta_n_i,
  output logic [7:0]       bus_rdata_o,
  output logic             cpu_clk_o,
  output logic             irq_n_o,
  // Memory selects
  output logic             prog0_cs_o,
  output logic             prog1_cs_o,
  output logic             ram_cs_o,
  // Displays and lamps
  output logic [3:0]       disp_strobe_o,
  output logic             sent_wr_o,
  output logic [4:0]       sent_addr_o,
  output logic [7:0]       sent_data_o,
  output logic             sentinel_err_o,
  output logic [2:0]       lamp_col_o,
  output logic [7:0]       lamp_row_o,
  // Keys and parallel lines
  output logic [3:0]       port_a_scan_lines_o,
  input  wire logic [7:0]  port_b_scan_lines_i,
  input  wire logic        remote_switch_in_i,
  output logic             buzzer_out_o,
  output logic             arm_lamp_out_o,
  // Serial link
  input  wire logic        osc_tick_i,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             tx_ready_o,
  output logic             link_up_o,
  input  wire logic        monitor_fault_i
);
  function automatic logic [7:0] decode(input logic [15:0] a, input logic mreq_n, input logic iorq_n);
    logic [7:0] s;
    s = 8'h00;
    if (!mreq_n) begin
      if (a[15:`OPC_PROG_LSB] == `OPC_PROG0_TAG) s[`OPC_CS_PROG0] = 1'b1;
      else if (a[15:`OPC_PROG_LSB] == `OPC_PROG1_TAG) s[`OPC_CS_PROG1] = 1'b1;
      else if (a[15:`OPC_RAM_LSB] == `OPC_RAM_TAG) s[`OPC_CS_RAM] = 1'b1;
    end else if (!iorq_n) begin
      if (a[7:4] == `OPC_IO_PIO) s[`OPC_CS_PIO] = 1'b1;
      else if (a[7:4] == `OPC_IO_CTC) s[`OPC_CS_CTC] = 1'b1;
      else if (a[7:4] == `OPC_IO_UART) s[`OPC_CS_UART] = 1'b1;
      else if (a[7:4] == `OPC_IO_DISP) s[`OPC_CS_DISP] = 1'b1;
      else if (a[7:5] == `OPC_IO_SENT) s[`OPC_CS_SENT] = 1'b1;
    end
    return s;
  endfunction

  function automatic logic even_par(input logic [7:0] d);
    return ^d;
  endfunction

  logic [7:0]         sel;
  logic               rd_q;
  logic               wr_q;
  logic               inta_q;
  logic               acc_rd;
  logic               acc_wr;
  logic [7:0]         next_rdata;
  logic [1:0]         reg_a;
  logic [11:0]        dwell;
  logic [1:0]         col;
  logic [1:0]         lamp_idx;
  logic [7:0]         key_prev [4];
  logic [7:0]         key_state [4];
  logic [1:0]         key_sel;
  logic [7:0]         lamp_mem [3];
  logic [7:0]         ctc_reload;
  logic [7:0]         ctc_count;
  logic               ctc_pend;
  logic [4:0]         osc_div;
  logic               ovs_tick;
  logic [3:0]         tx_ovs;
  logic [3:0]         rx_ovs;
  logic [3:0]         tx_bits;
  logic [3:0]         rx_bits;
  logic [10:0]        tx_shift;
  logic [8:0]         rx_shift;
  logic [7:0]         tx_last;
  logic [7:0]         rx_hold;
  logic               rx_full;
  logic               rx_done;
  logic               rx_err;
  logic               nak_pend;
  logic               resend;
  opc_pkg::opc_link_t link;
  opc_pkg::opc_tx_t   tx_st;
  opc_pkg::opc_rx_t   rx_st;
  logic               f_in_ready;
  logic               f_out_valid;
  logic               f_out_ready;
  logic [7:0]         f_out_data;

  // Bus accesses act once, on the first cycle of a strobe; the answer is ready next cycle
  assign sel    = decode(bus_addr_i, bus_mreq_n_i, bus_iorq_n_i);
  assign acc_rd = !bus_rd_n_i && rd_q;
  assign acc_wr = !bus_wr_n_i && wr_q;
  assign reg_a  = bus_addr_i[1:0];

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rd_q   <= 1'b1;
      wr_q   <= 1'b1;
      inta_q <= 1'b1;
    end else if (ce_i) begin
      rd_q   <= bus_rd_n_i;
      wr_q   <= bus_wr_n_i;
      inta_q <= bus_inta_n_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      prog0_cs_o    <= 1'b0;
      prog1_cs_o    <= 1'b0;
      ram_cs_o      <= 1'b0;
      disp_strobe_o <= 4'h0;
      sent_wr_o     <= 1'b0;
      sent_addr_o   <= 5'h00;
      sent_data_o   <= 8'h00;
    end else if (ce_i) begin
      prog0_cs_o    <= sel[`OPC_CS_PROG0];
      prog1_cs_o    <= sel[`OPC_CS_PROG1];
      ram_cs_o      <= sel[`OPC_CS_RAM];
      // Strobe 0..2 numeric groups, strobe 3 the lamp driver
      disp_strobe_o <= (sel[`OPC_CS_DISP] && acc_wr) ? 4'h1 << reg_a : 4'h0;
      sent_wr_o     <= sel[`OPC_CS_SENT] && acc_wr;
      if (sel[`OPC_CS_SENT] && acc_wr) begin
        sent_addr_o <= bus_addr_i[4:0];
        sent_data_o <= bus_data_i;
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (sel[`OPC_CS_PIO]) begin
      case (reg_a)
        `OPC_PIO_A: next_rdata = {~buzzer_out_o, remote_switch_in_i, ~arm_lamp_out_o, 1'b0,
                                  port_a_scan_lines_o};
        `OPC_PIO_B: next_rdata = key_state[key_sel];
        `OPC_PIO_SEL: next_rdata = {6'h00, key_sel};
        default: next_rdata = 8'h00;
      endcase
    end else if (sel[`OPC_CS_CTC]) begin
      case (reg_a)
        `OPC_CTC_RELOAD: next_rdata = ctc_reload;
        `OPC_CTC_COUNT: next_rdata = ctc_count;
        `OPC_CTC_STAT: next_rdata = {6'h00, rx_full, ctc_pend};
        default: next_rdata = 8'h00;
      endcase
    end else if (sel[`OPC_CS_UART]) begin
      case (reg_a)
        `OPC_UART_DATA: next_rdata = rx_hold;
        `OPC_UART_STAT: next_rdata = {4'h0, sentinel_err_o, link_up_o, f_in_ready, rx_full};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) bus_rdata_o <= 8'h00;
    else if (ce_i && acc_rd) bus_rdata_o <= next_rdata;
  end

  // Parallel port writes; bits 5 and 7 are inverted here before they drive the outputs
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      buzzer_out_o   <= 1'b1;
      arm_lamp_out_o <= 1'b1;
      key_sel        <= 2'h0;
    end else if (ce_i && acc_wr && sel[`OPC_CS_PIO]) begin
      if (reg_a == `OPC_PIO_A) begin
        buzzer_out_o   <= ~bus_data_i[`OPC_BUZ_BIT];
        arm_lamp_out_o <= ~bus_data_i[`OPC_ARM_BIT];
      end
      if (reg_a == `OPC_PIO_SEL) key_sel <= bus_data_i[1:0];
    end
  end

  // Key scan: one low column, rows sampled after the dwell, accepted on two equal scans
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      dwell               <= 12'h000;
      col                 <= 2'h0;
      port_a_scan_lines_o <= 4'he;
      for (int i = 0; i < 4; i++) begin
        key_prev[i]  <= 8'h00;
        key_state[i] <= 8'h00;
      end
    end else if (ce_i) begin
      if (dwell == 12'(`OPC_SCAN_DWELL_CYC - 1)) begin
        dwell         <= 12'h000;
        key_prev[col] <= ~port_b_scan_lines_i;
        if (key_prev[col] == ~port_b_scan_lines_i) key_state[col] <= ~port_b_scan_lines_i;
        col                 <= col + 1'b1;
        port_a_scan_lines_o <= ~(4'h1 << (col + 1'b1));
      end else begin
        dwell <= dwell + 1'b1;
      end
    end
  end

  // Lamp driver: rows written through strobe 3, columns refreshed in turn with the key scan
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      lamp_idx   <= 2'h0;
      lamp_col_o <= 3'h0;
      lamp_row_o <= 8'h00;
      for (int i = 0; i < 3; i++) lamp_mem[i] <= 8'h00;
    end else if (ce_i) begin
      if (sel[`OPC_CS_DISP] && acc_wr && reg_a == 2'h3 && bus_addr_i[3:2] != 2'h3) begin
        lamp_mem[bus_addr_i[3:2]] <= bus_data_i;
      end
      if (dwell == 12'h000) begin
        lamp_idx   <= (lamp_idx == 2'h2) ? 2'h0 : lamp_idx + 1'b1;
        lamp_col_o <= 3'h1 << lamp_idx;
        lamp_row_o <= lamp_mem[lamp_idx];
      end
    end
  end

  // Processor clock from the reference divided by two
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) cpu_clk_o <= 1'b0;
    else if (ce_i) cpu_clk_o <= ~cpu_clk_o;
  end

  // Counter-timer counts processor clocks; interrupt acknowledge or status write clears, a new zero wins
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ctc_reload <= `OPC_CTC_RELOAD_RST;
      ctc_count  <= `OPC_CTC_RELOAD_RST;
      ctc_pend   <= 1'b0;
      irq_n_o    <= 1'b1;
    end else if (ce_i) begin
      if (acc_wr && sel[`OPC_CS_CTC] && reg_a == `OPC_CTC_RELOAD) ctc_reload <= bus_data_i;
      if (cpu_clk_o) ctc_count <= (ctc_count == 8'h00) ? ctc_reload : ctc_count - 1'b1;
      if (cpu_clk_o && ctc_count == 8'h00) ctc_pend <= 1'b1;
      else if ((!bus_inta_n_i && inta_q) || (acc_wr && sel[`OPC_CS_CTC] && reg_a == `OPC_CTC_STAT)) begin
        ctc_pend <= 1'b0;
      end
      irq_n_o <= !(ctc_pend || rx_full);
    end
  end

  // Oversample tick, 16 per bit, from the separate serial oscillator
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      osc_div  <= 5'h00;
      ovs_tick <= 1'b0;
    end else if (ce_i) begin
      ovs_tick <= osc_tick_i && osc_div == `OPC_UART_OSC_DIV;
      if (osc_tick_i) osc_div <= (osc_div == `OPC_UART_OSC_DIV) ? 5'h00 : osc_div + 1'b1;
    end
  end

  opc_fifo #(.WIDTH(8), .DEPTH(`OPC_FIFO_DEPTH)) u_tx_fifo (
    .clk_i       (ref_clk_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .in_valid_i  (acc_wr && sel[`OPC_CS_UART] && reg_a == `OPC_UART_DATA),
    .in_ready_o  (f_in_ready),
    .in_data_i   (bus_data_i),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready),
    .out_data_o  (f_out_data)
  );

  // Queued data leaves only on an established link with no retry or refusal waiting
  assign f_out_ready = ce_i && tx_st == opc_pkg::TX_IDLE && link == opc_pkg::LNK_UP && !nak_pend && !resend
                       && ovs_tick && tx_ovs == 4'h0;

  // Transmitter: start, 8 data, even parity, stop
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      tx_st      <= opc_pkg::TX_IDLE;
      tx_shift   <= '1;
      tx_bits    <= 4'h0;
      tx_ovs     <= 4'h0;
      tx_last    <= 8'h00;
      txd_o      <= 1'b1;
      tx_ready_o <= 1'b0;
    end else if (ce_i) begin
      tx_ready_o <= f_in_ready;
      if (ovs_tick) tx_ovs <= tx_ovs + 1'b1;
      case (tx_st)
        opc_pkg::TX_IDLE: begin
          if (ovs_tick && tx_ovs == 4'h0) begin
            if (nak_pend) begin
              tx_shift <= {1'b1, even_par(`OPC_NAK_BYTE), `OPC_NAK_BYTE, 1'b0};
              tx_st    <= opc_pkg::TX_SHIFT;
            end else if (resend) begin
              tx_shift <= {1'b1, even_par(tx_last), tx_last, 1'b0};
              tx_st    <= opc_pkg::TX_SHIFT;
            end else if (link == opc_pkg::LNK_HUNT) begin
              tx_shift <= {1'b1, even_par(`OPC_SYNC_BYTE), `OPC_SYNC_BYTE, 1'b0};
              tx_st    <= opc_pkg::TX_SHIFT;
            end else if (f_out_valid) begin
              tx_shift <= {1'b1, even_par(f_out_data), f_out_data, 1'b0};
              tx_last  <= f_out_data;
              tx_st    <= opc_pkg::TX_SHIFT;
            end
            tx_bits <= 4'h0;
          end
        end
        opc_pkg::TX_SHIFT: begin
          txd_o <= tx_shift[0];
          if (ovs_tick && tx_ovs == 4'hf) begin
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_bits  <= tx_bits + 1'b1;
            if (tx_bits == `OPC_TX_BITS) tx_st <= opc_pkg::TX_IDLE;
          end
        end
        default: tx_st <= opc_pkg::TX_IDLE;
      endcase
    end
  end

  // Receiver: start confirmed mid-bit, parity and stop checked
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rx_st    <= opc_pkg::RX_IDLE;
      rx_ovs   <= 4'h0;
      rx_bits  <= 4'h0;
      rx_shift <= 9'h000;
      rx_done  <= 1'b0;
      rx_err   <= 1'b0;
    end else if (ce_i) begin
      rx_done <= 1'b0;
      rx_err  <= 1'b0;
      if (ovs_tick) begin
        rx_ovs <= rx_ovs + 1'b1;
        case (rx_st)
          opc_pkg::RX_IDLE: begin
            rx_ovs <= 4'h0;
            if (!rxd_i) rx_st <= opc_pkg::RX_START;
          end
          opc_pkg::RX_START: if (rx_ovs == `OPC_UART_OVS_MID) begin
            rx_ovs  <= 4'h0;
            rx_bits <= 4'h0;
            rx_st   <= rxd_i ? opc_pkg::RX_IDLE : opc_pkg::RX_DATA;
          end
          opc_pkg::RX_DATA: if (rx_ovs == 4'hf) begin
            rx_shift <= {rxd_i, rx_shift[8:1]};
            rx_bits  <= rx_bits + 1'b1;
            if (rx_bits == `OPC_RX_BITS - 1'b1) rx_st <= opc_pkg::RX_STOP;
          end
          opc_pkg::RX_STOP: if (rx_ovs == 4'hf) begin
            rx_st   <= opc_pkg::RX_IDLE;
            rx_done <= rxd_i && (even_par(rx_shift[7:0]) == rx_shift[8]);
            rx_err  <= !rxd_i || (even_par(rx_shift[7:0]) != rx_shift[8]);
          end
          default: rx_st <= opc_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // Link control: hunt with sync bytes until an error-free acknowledge byte; errors on an up link refuse, a received refusal resends
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      link           <= opc_pkg::LNK_HUNT;
      link_up_o      <= 1'b0;
      nak_pend       <= 1'b0;
      resend         <= 1'b0;
      rx_hold        <= 8'h00;
      rx_full        <= 1'b0;
      sentinel_err_o <= 1'b0;
    end else if (ce_i) begin
      link_up_o <= link == opc_pkg::LNK_UP;
      if (tx_st == opc_pkg::TX_IDLE && ovs_tick && tx_ovs == 4'h0) begin
        if (nak_pend) nak_pend <= 1'b0;
        else resend <= 1'b0;
      end
      if (monitor_fault_i) begin
        link <= opc_pkg::LNK_HUNT;
      end else if (rx_err) begin
        sentinel_err_o <= 1'b1;
        if (link == opc_pkg::LNK_UP) nak_pend <= 1'b1;
      end else if (rx_done) begin
        sentinel_err_o <= 1'b0;
        if (link == opc_pkg::LNK_HUNT) begin
          if (rx_shift[7:0] == `OPC_ACK_BYTE) link <= opc_pkg::LNK_UP;
        end else if (rx_shift[7:0] == `OPC_NAK_BYTE) begin
          resend <= 1'b1;
        end
      end
      // A new byte wins over the read that empties the holding register
      if (rx_done && link == opc_pkg::LNK_UP && rx_shift[7:0] != `OPC_NAK_BYTE) begin
        rx_hold <= rx_shift[7:0];
        rx_full <= 1'b1;
      end else if (acc_rd && sel[`OPC_CS_UART] && reg_a == `OPC_UART_DATA) begin
        rx_full <= 1'b0;
      end
    end
  end

  a_cs_exclusive: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $onehot0({prog0_cs_o, prog1_cs_o, ram_cs_o, |disp_strobe_o, sent_wr_o}))
    else $error("more than one select active");
  a_ram_select: assert property (@(posedge ref_clk_i) disable iff (!rstn_i || !ce_i)
    (!bus_mreq_n_i && bus_addr_i[15:13] == 3'h4) |=> ram_cs_o && !prog0_cs_o)
    else $error("ram not selected");
  a_disp_strobe: assert property (@(posedge ref_clk_i) disable iff (!rstn_i || !ce_i)
    (acc_wr && sel[`OPC_CS_DISP]) |=> $onehot(disp_strobe_o) ##1 disp_strobe_o == 4'h0)
    else $error("display strobe wrong");
  a_buzzer_invert: assert property (@(posedge ref_clk_i) disable iff (!rstn_i || !ce_i)
    (acc_wr && sel[`OPC_CS_PIO] && reg_a == `OPC_PIO_A) |=> buzzer_out_o == !$past(bus_data_i[7])
    && arm_lamp_out_o == !$past(bus_data_i[5]))
    else $error("port outputs not inverted");
  a_scan_one_col: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $countones(~port_a_scan_lines_o) == 1)
    else $error("scan must drive one column");
  a_clk_half: assert property (@(posedge ref_clk_i) disable iff (!rstn_i || !ce_i)
    cpu_clk_o |=> !cpu_clk_o ##1 cpu_clk_o)
    else $error("processor clock not halved");
  a_rx_irq: assert property (@(posedge ref_clk_i) disable iff (!rstn_i || !ce_i)
    rx_full |=> !irq_n_o)
    else $error("received byte raised no interrupt");
  a_err_message: assert property (@(posedge ref_clk_i) disable iff (!rstn_i || !ce_i)
    (rx_err && !monitor_fault_i) |=> sentinel_err_o)
    else $error("link error not shown");
  a_read_nowait: assert property (@(posedge ref_clk_i) disable iff (!rstn_i || !ce_i)
    (acc_rd && sel[`OPC_CS_CTC] && reg_a == `OPC_CTC_RELOAD) |=> bus_rdata_o == $past(ctc_reload))
    else $error("read answer late");
endmodule

//--- dv/opc_console_model.sv
// Behavioural console on the far side of the serial link.
`timescale 1ns/100ps
module opc_console_model #(
  parameter int BIT_CYC = 384
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  logic [7:0] got[$];
  logic [7:0] last = 8'h00;
  initial line_o = 1'b1;
  // Frame: start, eight data bits first bit lowest, even parity, stop
  task automatic send(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {1'b1, ^b ^ bad, b, 1'b0};
    for (int k = 0; k < 11; k++) begin
      line_o <= f[k];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    last = b;
  endtask
  always begin : rx
    logic [7:0] b;
    @(negedge line_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int k = 0; k < 8; k++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      b[k] = line_i;
    end
    // Skip parity and stop so a held line is not taken as a new start
    repeat (2 * BIT_CYC) @(posedge clk_i);
    got.push_back(b);
    // Every sync is answered, so a panel that fell back to hunting is taken up again
    if (b == 8'h16) begin
      send(8'h06, 1'b0);
    end else if (b == 8'h15) begin
      send(last, 1'b0);
    end
  end
endmodule

//--- dv/opc_top_tb.sv
// Self-checking bench of the operator panel controller.
`timescale 1ns/100ps
module opc_top_tb;
  logic        ref_clk_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        mreq_n = 1'b1, iorq_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, remote = 1'b0;
  logic [7:0]  rdata, rv, d;
  logic [2:0]  cs, csv;
  logic [3:0]  strb, sv, scan;
  logic        irq_n, buz, arm, txd, rxd, link_up, serr;
  logic        cpu, txr, sw, swv, fault = 1'b0;
  logic [7:0]  rows, km = 8'h00, sd, lr;
  logic [4:0]  sa;
  logic [2:0]  lc;
  logic [1:0]  kc = 2'h0;
  logic [15:0] a;
  int          errors = 0, check_count = 0, n;
  opc_top i_opc_top (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .bus_addr_i(addr), .bus_data_i(wdata),
    .bus_mreq_n_i(mreq_n), .bus_iorq_n_i(iorq_n), .bus_rd_n_i(rd_n), .bus_wr_n_i(wr_n), .bus_inta_n_i(1'b1),
    .bus_rdata_o(rdata), .cpu_clk_o(cpu), .irq_n_o(irq_n), .prog0_cs_o(cs[0]), .prog1_cs_o(cs[1]), .ram_cs_o(cs[2]),
    .disp_strobe_o(strb), .sent_wr_o(sw), .sent_addr_o(sa), .sent_data_o(sd), .sentinel_err_o(serr),
    .lamp_col_o(lc), .lamp_row_o(lr), .port_a_scan_lines_o(scan), .port_b_scan_lines_i(rows),
    .remote_switch_in_i(remote), .buzzer_out_o(buz), .arm_lamp_out_o(arm), .osc_tick_i(1'b1), .rxd_i(rxd), .txd_o(txd),
    .tx_ready_o(txr), .link_up_o(link_up), .monitor_fault_i(fault));
  // Oscillator tick held high: one oversample step every 24 clocks keeps frames short
  opc_console_model i_opc_console_model (.clk_i(ref_clk_i), .line_i(txd), .line_o(rxd));
  initial forever #20 ref_clk_i = ~ref_clk_i;
  // Key matrix: the pressed key pulls its rows low only while its column is driven
  always @(posedge ref_clk_i) rows <= scan[kc] ? 8'hff : ~km;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic acc(input logic [15:0] ad, input logic [7:0] dv, input logic wr, input logic mem);
    @(posedge ref_clk_i);
    addr <= ad; wdata <= dv; mreq_n <= ~mem; iorq_n <= mem; wr_n <= ~wr; rd_n <= wr;
    @(posedge ref_clk_i); #1;
    sv = strb;
    swv = sw;
    @(posedge ref_clk_i); #1;
    rv = rdata; csv = cs;
    @(posedge ref_clk_i);
    mreq_n <= 1'b1; iorq_n <= 1'b1; wr_n <= 1'b1; rd_n <= 1'b1;
    @(posedge ref_clk_i);
  endtask
  function automatic logic [7:0] mem_exp(input logic [15:0] ad);
    return ad < 16'h4000 ? 8'h01 : ad < 16'h8000 ? 8'h02 : ad < 16'ha000 ? 8'h04 : 8'h00;
  endfunction
  initial begin
    logic [15:0] bnd[6];
    bnd = '{16'h3fff, 16'h4000, 16'h7fff, 16'h8000, 16'h9fff, 16'ha000};
    n = $urandom(32'h2180);
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    km     <= 8'($urandom);
    kc     <= 2'($urandom);
    @(posedge ref_clk_i); #1;
    chk({2'h0, cpu, txr, irq_n, buz, arm, txd}, 8'h3f);
    chk({4'h0, scan}, 8'h0e);
    @(posedge ref_clk_i); #1;
    chk({7'h00, cpu}, 8'h00);
    for (int i = 0; i < 16; i++) begin
      a = i < 6 ? bnd[i] : 16'($urandom);
      acc(a, 8'h00, 1'b0, 1'b1);
      chk({5'h00, csv}, mem_exp(a));
    end
    d = 8'($urandom);
    remote <= d[0];
    acc(16'h0000, d, 1'b1, 1'b0);
    chk({6'h00, buz, arm}, {6'h00, ~d[7], ~d[5]});
    acc(16'h0000, 8'h00, 1'b0, 1'b0);
    chk({7'h00, rv[6]}, {7'h00, d[0]});
    for (int i = 0; i < 4; i++) begin
      acc(16'h0030 + 16'(i), d, 1'b1, 1'b0);
      chk({4'h0, sv}, {4'h0, 4'h1 << i});
    end
    acc(16'h0010, 8'h00, 1'b0, 1'b0);
    chk(rv, 8'hff);
    chk({7'h00, 1'($countones(~scan) == 1)}, 8'h01);
    n = 0;
    while (link_up !== 1'b1 && n < 30000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk({7'h00, link_up}, 8'h01);
    if (n >= 30000) summarize();
    chk(i_opc_console_model.got[0], 8'h16);
    d = 8'($urandom);
    // Refusal codes are consumed by the link, not handed over as data; sync is avoided too
    if (d == 8'h15 || d == 8'h16) d = 8'h5a;
    i_opc_console_model.send(d, 1'b0);
    repeat (20) @(posedge ref_clk_i);
    acc(16'h0021, 8'h00, 1'b0, 1'b0);
    chk({7'h00, rv[0]}, 8'h01);
    chk({7'h00, irq_n}, 8'h00);
    acc(16'h0020, 8'h00, 1'b0, 1'b0);
    chk(rv, d);
    i_opc_console_model.send(d, 1'b1);
    repeat (20) @(posedge ref_clk_i); #1;
    chk({7'h00, serr}, 8'h01);
    n = 0;
    while (i_opc_console_model.got[$] !== 8'h15 && n < 10000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk(i_opc_console_model.got[$], 8'h15);
    repeat (4300) @(posedge ref_clk_i);
    acc(16'h0020, 8'h00, 1'b0, 1'b0);
    chk(rv, d);
    chk({7'h00, serr}, 8'h00);
    acc(16'h0020, d, 1'b1, 1'b0);
    n = 0;
    while (i_opc_console_model.got[$] === 8'h15 && n < 10000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk(i_opc_console_model.got[$], d);
    acc(16'h0002, {6'h00, kc}, 1'b1, 1'b0);
    acc(16'h0001, 8'h00, 1'b0, 1'b0);
    chk(rv, km);
    acc(16'h0040 + 16'(d[4:0]), d, 1'b1, 1'b0);
    chk({swv, 2'h0, sa}, {1'b1, 2'h0, d[4:0]});
    chk(sd, d);
    acc(16'h0033, km, 1'b1, 1'b0);
    // One full round of three columns, so the shown column 0 was loaded after the write
    repeat (7500) @(posedge ref_clk_i);
    #1;
    n = 0;
    while (lc !== 3'h1 && n < 8000) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk({5'h00, lc}, 8'h01);
    chk(lr, km);
    fault <= 1'b1;
    @(posedge ref_clk_i);
    fault <= 1'b0;
    @(posedge ref_clk_i); #1;
    chk({7'h00, link_up}, 8'h00);
    n = 0;
    while (link_up !== 1'b1 && n < 30000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk({7'h00, link_up}, 8'h01);
    summarize();
  end
endmodule
